// ===== design/fir_pkg.sv
// fir_pkg: widths, defaults and reset values shared by the eight-tap filter and its stages.
// assumes one 100 MHz clock; the sample rate is that clock divided by the multiplex factor.
// How it works
// - build-time parameter picks parallel or serial operand loading for the stages, in direct mode only
// - parallel loading drives every stage operand straight from filter logic, no chaining
// - serial loading chains operand registers through and across stages as filter taps
// - samples and coefficients are both 18 bits wide in every mode
// - multiplexed mode computes eight taps on four multipliers at twice the sample rate
// - sample history shifts once per sample period, all taps offered in parallel
// - coefficients come from a ROM read on the fast clock into the stage
// - first fast cycle applies four coefficients and keeps the partial sum
// - first cycle enables only odd taps; partial sum held outside the stage
// - second cycle enables only the even taps
// - second cycle adds new partial to stored one; first cycles give no output
// - result equals full eight-tap weighted sum of current and seven older samples
// - the coefficient schedule repeats forever, one sample shift per period
// - factors above two accumulate partials across cycles in an accumulator
// - accumulator restarts from zero at each new sample's first partial
// - fast side reads buffered samples at factor times the sample rate
// - each four-multiplier stage yields a 38-bit sum
// - serial chain output feeds the next operand register, across stage borders too
// - an adder outside the stages sums the stage outputs

package fir_pkg;
   localparam int          SAMPLE_W     = 18;
   localparam int          COEF_W       = 18;
   localparam int          MULTS        = 4;
   localparam int          STAGE_SUM_W  = 38;
   localparam int          TDM_FACTOR   = 2;
   localparam bit          LOAD_SERIAL  = 1'b0;
   localparam logic [17:0] COEF_DEFAULT = 18'h00001;
   localparam logic [17:0] SAMPLE_RESET = 18'h00000;
endpackage

// ===== design/mult_stage_if.sv
// mult_stage_if: operands, load strobes, serial chain and sum of one four-multiplier stage.
// assumes the stage and its controller share one clock.
`timescale 1ns/1ps
interface mult_stage_if;
   logic signed [fir_pkg::SAMPLE_W-1:0]    x_par     [fir_pkg::MULTS];
   logic signed [fir_pkg::COEF_W-1:0]      coef      [fir_pkg::MULTS];
   logic        [fir_pkg::MULTS-1:0]       load_en;
   logic                                   serial_sel;
   logic signed [fir_pkg::SAMPLE_W-1:0]    chain_in;
   logic signed [fir_pkg::SAMPLE_W-1:0]    chain_out;
   logic signed [fir_pkg::STAGE_SUM_W-1:0] sum;

   modport stage (input x_par, input coef, input load_en, input serial_sel,
                  input chain_in, output chain_out, output sum);
   modport ctrl  (output x_par, output coef, output load_en, output serial_sel,
                  output chain_in, input chain_out, input sum);
endinterface // mult_stage_if

// ===== design/four_mult_stage.sv
// four_mult_stage: four operand register pairs, four 18x18 multipliers and their adder.
// assumes the controller holds load_en low on cycles the operands must keep their value.
`timescale 1ns/1ps
module four_mult_stage (
   input wire logic    clk,
   input wire logic    srst,
   mult_stage_if.stage bus
);
   logic signed [fir_pkg::SAMPLE_W-1:0]    x_reg     [fir_pkg::MULTS];
   logic signed [fir_pkg::SAMPLE_W-1:0]    x_next    [fir_pkg::MULTS];
   logic signed [fir_pkg::COEF_W-1:0]      h_reg     [fir_pkg::MULTS];
   logic signed [fir_pkg::COEF_W-1:0]      h_next    [fir_pkg::MULTS];
   logic signed [fir_pkg::SAMPLE_W-1:0]    chain_src [fir_pkg::MULTS];
   logic signed [fir_pkg::STAGE_SUM_W-1:0] sum_c;

   always_comb begin
      chain_src[0] = bus.chain_in;
      for (int k = 1; k < fir_pkg::MULTS; k++) begin
         chain_src[k] = x_reg[k-1];
      end
   end

   always_comb begin
      for (int k = 0; k < fir_pkg::MULTS; k++) begin
         x_next[k] = x_reg[k];
         h_next[k] = h_reg[k];
         if (bus.load_en[k]) begin
            // each sample operand register has its own mux: chain neighbour or outside operand
            x_next[k] = bus.serial_sel ? chain_src[k] : bus.x_par[k];
            h_next[k] = bus.coef[k];
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int k = 0; k < fir_pkg::MULTS; k++) begin
         if (srst) begin
            x_reg[k] <= fir_pkg::SAMPLE_RESET;
            h_reg[k] <= fir_pkg::SAMPLE_RESET;
         end else begin
            x_reg[k] <= x_next[k];
            h_reg[k] <= h_next[k];
         end
      end
   end

   // sized casts widen operands before multiplying, so no product bits are lost
   always_comb begin
      sum_c = '0;
      for (int k = 0; k < fir_pkg::MULTS; k++) begin
         sum_c = sum_c + fir_pkg::STAGE_SUM_W'(x_reg[k]) * fir_pkg::STAGE_SUM_W'(h_reg[k]);
      end
   end

   assign bus.sum       = sum_c;
   assign bus.chain_out = x_reg[fir_pkg::MULTS-1];
endmodule // four_mult_stage

// ===== design/tdm_fir_filter_8tap.sv
// tdm_fir_filter_8tap: FIR filter of 4*FACTOR taps, direct or time-multiplexed on one stage.
// assumes sample_in is stable for a whole sample period and changes after sample_ce.
`timescale 1ns/1ps
module tdm_fir_filter_8tap #(
   parameter int                      FACTOR      = fir_pkg::TDM_FACTOR,
   parameter bit                      LOAD_SERIAL = fir_pkg::LOAD_SERIAL,
   parameter logic [fir_pkg::COEF_W*fir_pkg::MULTS*FACTOR-1:0] COEF_INIT =
      {(fir_pkg::MULTS*FACTOR){fir_pkg::COEF_DEFAULT}}
) (
   input  wire logic                                   clk,
   input  wire logic                                   srst,
   input  wire logic                                   tdm_en,
   input  wire logic signed [fir_pkg::SAMPLE_W-1:0]    sample_in,
   output logic                                        sample_ce,
   output logic signed [fir_pkg::STAGE_SUM_W+$clog2(FACTOR)-1:0] y_out,
   output logic                                        y_valid
);
   localparam int TAPS  = fir_pkg::MULTS * FACTOR;
   localparam int OUT_W = fir_pkg::STAGE_SUM_W + $clog2(FACTOR);
   localparam int PH_W  = (FACTOR > 1) ? $clog2(FACTOR) : 1;
   localparam logic [PH_W-1:0] PH_LAST  = PH_W'(FACTOR - 1);
   localparam logic [PH_W-1:0] PH_FIRST = '0;

   // coefficient index of multiplier k when group j of taps is active
   function automatic int tap_index(input int k, input int j);
      return FACTOR * k + j;
   endfunction

   // later phases take lower groups, so the newest sample lands in the last cycle
   function automatic int group_of(input logic [PH_W-1:0] ph);
      return FACTOR - 1 - int'(ph);
   endfunction

   // sample-period divider
   logic [PH_W-1:0] phase_reg;
   logic [PH_W-1:0] phase_next;
   logic            last_phase;
   int              grp;

   // sample history and ROM
   logic signed [fir_pkg::SAMPLE_W-1:0] dl_reg  [TAPS-1];
   logic signed [fir_pkg::SAMPLE_W-1:0] dl_next [TAPS-1];
   logic signed [fir_pkg::SAMPLE_W-1:0] taps_c  [TAPS];
   logic signed [fir_pkg::COEF_W-1:0]   rom     [TAPS];
   logic        [TAPS-1:0]              tap_en;

   // stage controls
   logic                                   serial_on;
   logic signed [fir_pkg::STAGE_SUM_W-1:0] stage_sum [FACTOR];

   // result path
   logic                    pend_tdm_reg;
   logic                    pend_tdm_next;
   logic                    pend_first_reg;
   logic                    pend_first_next;
   logic                    pend_out_reg;
   logic                    pend_out_next;
   logic signed [OUT_W-1:0] acc_reg;
   logic signed [OUT_W-1:0] acc_next;
   logic signed [OUT_W-1:0] y_reg;
   logic signed [OUT_W-1:0] y_next;
   logic                    y_valid_reg;
   logic                    y_valid_next;
   logic signed [OUT_W-1:0] partial_c;
   logic signed [OUT_W-1:0] total_c;

   // ---------------- sample-period divider ----------------
   assign last_phase = (phase_reg == PH_LAST);
   assign grp        = group_of(phase_reg);

   always_comb begin
      if (last_phase) begin
         phase_next = PH_FIRST;
      end else begin
         phase_next = phase_reg + PH_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         phase_reg <= PH_FIRST;
      end else begin
         phase_reg <= phase_next;
      end
   end

   // the source must hold sample_in for the period and step it after this strobe
   assign sample_ce = last_phase;

   // ---------------- sample history ----------------
   // the history bank is what lets the fast side reread samples FACTOR times per period,
   // standing in for a rate-changing FIFO; it costs registers, not a memory block
   always_comb begin
      for (int i = 0; i < TAPS - 1; i++) begin
         dl_next[i] = dl_reg[i];
      end
      if (last_phase) begin
         dl_next[0] = sample_in;
         for (int i = 1; i < TAPS - 1; i++) begin
            dl_next[i] = dl_reg[i-1];
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int i = 0; i < TAPS - 1; i++) begin
         if (srst) begin
            dl_reg[i] <= fir_pkg::SAMPLE_RESET;
         end else begin
            dl_reg[i] <= dl_next[i];
         end
      end
   end

   // tap 0 is the current sample, tap i the sample i periods old
   always_comb begin
      taps_c[0] = sample_in;
      for (int i = 1; i < TAPS; i++) begin
         taps_c[i] = dl_reg[i-1];
      end
   end

   // coefficient ROM, read on the fast clock by the stage coefficient registers
   genvar r;
   generate
      for (r = 0; r < TAPS; r++) begin : g_rom
         assign rom[r] = COEF_INIT[r*fir_pkg::COEF_W +: fir_pkg::COEF_W];
      end
   endgenerate

   // taps whose operand registers take part this cycle in multiplexed mode
   always_comb begin
      for (int i = 0; i < TAPS; i++) begin
         tap_en[i] = tdm_en && ((i % FACTOR) == grp);
      end
   end

   // ---------------- multiplier stages ----------------
   // serial chaining only makes sense when every tap has its own multiplier
   assign serial_on = LOAD_SERIAL && !tdm_en;

   mult_stage_if stg [FACTOR] ();

   genvar s;
   generate
      for (s = 0; s < FACTOR; s++) begin : g_stage
         four_mult_stage u_stage (
            .clk  (clk),
            .srst (srst),
            .bus  (stg[s])
         );

         if (s == 0) begin : g_head
            assign stg[s].chain_in = sample_in;
         end else begin : g_link
            assign stg[s].chain_in = stg[s-1].chain_out;
         end

         assign stage_sum[s] = stg[s].sum;

         always_comb begin
            stg[s].serial_sel = serial_on;
            stg[s].load_en    = '0;
            for (int k = 0; k < fir_pkg::MULTS; k++) begin
               stg[s].x_par[k] = taps_c[fir_pkg::MULTS*s + k];
               stg[s].coef[k]  = rom[fir_pkg::MULTS*s + k];
            end
            if (tdm_en) begin
               // only the head stage works; the others keep their operands
               if (s == 0) begin
                  for (int k = 0; k < fir_pkg::MULTS; k++) begin
                     stg[s].x_par[k]   = taps_c[tap_index(k, grp)];
                     stg[s].coef[k]    = rom[tap_index(k, grp)];
                     stg[s].load_en[k] = tap_en[tap_index(k, grp)];
                  end
               end
            end else if (last_phase) begin
               stg[s].load_en = '1;
            end
         end
      end
   endgenerate

   // ---------------- result path ----------------
   // operands load in one cycle and their sum is used in the next
   always_comb begin
      pend_tdm_next   = tdm_en;
      pend_first_next = tdm_en && (phase_reg == PH_FIRST);
      pend_out_next   = last_phase;
   end

   always_comb begin
      partial_c = OUT_W'(stage_sum[0]);
      total_c   = '0;
      for (int i = 0; i < FACTOR; i++) begin
         total_c = total_c + OUT_W'(stage_sum[i]);
      end
   end

   always_comb begin
      acc_next     = acc_reg;
      y_next       = y_reg;
      y_valid_next = 1'b0;
      if (pend_tdm_reg) begin
         if (pend_out_reg) begin
            y_next       = acc_reg + partial_c;
            y_valid_next = 1'b1;
         end else if (pend_first_reg) begin
            acc_next = partial_c;
         end else begin
            acc_next = acc_reg + partial_c;
         end
      end else if (pend_out_reg) begin
         y_next       = total_c;
         y_valid_next = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pend_tdm_reg   <= 1'b0;
         pend_first_reg <= 1'b0;
         pend_out_reg   <= 1'b0;
         acc_reg        <= '0;
         y_reg          <= '0;
         y_valid_reg    <= 1'b0;
      end else begin
         pend_tdm_reg   <= pend_tdm_next;
         pend_first_reg <= pend_first_next;
         pend_out_reg   <= pend_out_next;
         acc_reg        <= acc_next;
         y_reg          <= y_next;
         y_valid_reg    <= y_valid_next;
      end
   end

   assign y_out   = y_reg;
   assign y_valid = y_valid_reg;
endmodule // tdm_fir_filter_8tap

// ===== sim/tdm_fir_sva.sv
// tdm_fir_sva: port-level timing and value checks for the eight-tap filter.
// assumes one clock, a synchronous active-high reset held at least two edges.
`timescale 1ns/1ps
module tdm_fir_sva #(
   parameter int FACTOR = 2
) (
   input wire logic                                                clk,
   input wire logic                                                srst,
   input wire logic                                                tdm_en,
   input wire logic signed [fir_pkg::SAMPLE_W-1:0]                 sample_in,
   input wire logic                                                sample_ce,
   input wire logic signed [fir_pkg::STAGE_SUM_W+$clog2(FACTOR)-1:0] y_out,
   input wire logic                                                y_valid
);
   // history depth and strobe spacing follow the build's factor
   localparam int TAPS   = fir_pkg::MULTS * FACTOR;
   localparam int CE_GAP = FACTOR - 1;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   int ph_reg;
   int zrun_reg;

   // zrun counts trailing zero samples; history is all zero after reset
   always_ff @(posedge clk) begin
      if (srst) begin
         ph_reg   <= 0;
         zrun_reg <= TAPS;
      end else begin
         ph_reg <= (ph_reg == FACTOR - 1) ? 0 : ph_reg + 1;
         if (sample_ce) begin
            zrun_reg <= (sample_in != 0) ? 0 : ((zrun_reg < TAPS) ? zrun_reg + 1 : TAPS);
         end
      end
   end

   sequence s_result;
      ##2 y_valid ##1 !y_valid;
   endsequence

   sequence s_first_period;
      !sample_ce ##CE_GAP sample_ce;
   endsequence

   ce_phase_a: assert property (sample_ce == (ph_reg == FACTOR - 1))
      else $error("sample strobe out of phase");
   ce_pulse_a: assert property (sample_ce |=> !sample_ce)
      else $error("sample strobe longer than one cycle");
   first_ce_a: assert property ($fell(srst) |-> s_first_period)
      else $error("first period does not start on the odd-tap cycle");
   result_lat_a: assert property (sample_ce |-> s_result)
      else $error("result strobe not two cycles after sample");
   valid_cause_a: assert property (y_valid |-> $past(sample_ce, 2))
      else $error("result strobe without a completed period");
   y_hold_a: assert property ($changed(y_out) |-> y_valid)
      else $error("output changed without strobe");
   reset_clear_a: assert property ($fell(srst) |-> (y_out == '0) && !y_valid)
      else $error("output not cleared by reset");
   zero_out_a: assert property ((sample_ce && sample_in == '0 && zrun_reg >= TAPS - 1)
                                |-> ##2 (y_out == '0))
      else $error("all-zero history gave nonzero result");
endmodule // tdm_fir_sva

bind tdm_fir_filter_8tap tdm_fir_sva #(.FACTOR(FACTOR)) u_sva (
   .clk(clk), .srst(srst), .tdm_en(tdm_en), .sample_in(sample_in),
   .sample_ce(sample_ce), .y_out(y_out), .y_valid(y_valid));

// ===== sim/sample_source.sv
// sample_source: upstream partner offering one held sample per sample period.
// assumes the filter's strobe marks the last fast cycle of each period.
`timescale 1ns/1ps
module sample_source (
   input  wire logic               clk,
   input  wire logic               srst,
   input  wire logic               sample_ce,
   input  wire logic signed [17:0] next_val,
   output logic signed [17:0]      sample_in
);
   // new value lands on the strobe edge, so it holds for the whole next period
   always_ff @(posedge clk) begin
      if (srst) begin
         sample_in <= 18'sh00000;
      end else if (sample_ce) begin
         sample_in <= next_val;
      end
   end
endmodule // sample_source

// ===== sim/tdm_fir_filter_8tap_tb.sv
// tdm_fir_filter_8tap_tb: streams samples through parallel, serial and four-cycle builds,
// each in both modes.
// assumes the design, checker and sample_source are compiled first.
`timescale 1ns/1ps
module tdm_fir_filter_8tap_tb;
   // distinct taps so an odd/even swap shows; extremes exercise the full width
   localparam logic [143:0] COEFS = {18'h3FFF8, 18'h00007, 18'h00006, 18'h00005,
                                     18'h00004, 18'h00003, 18'h00002, 18'h1FFFF};
   // sixteen distinct taps for the factor-four build, so a wrong group shows
   localparam logic [287:0] COEFS4 = {18'h0000F, 18'h3FFF0, 18'h0000D, 18'h0000C,
                                      18'h0000B, 18'h0000A, 18'h00009, 18'h00008, COEFS};
   logic signed [17:0] sample_in4;
   logic               sample_ce4;
   logic               y_valid4;
   logic signed [39:0] y_out4;
   logic signed [17:0] hist4 [16];
   logic signed [39:0] expq4 [$];
   logic               clk;
   logic               srst;
   logic               tdm_en;
   logic signed [17:0] next_val;
   logic signed [17:0] sample_in;
   logic               sample_ce;
   logic               y_valid;
   logic               y_valid_s;
   logic signed [38:0] y_out;
   logic signed [38:0] y_out_s;
   logic signed [17:0] hist [8];
   logic signed [38:0] expq [$];
   int                 miscompares;
   int                 n_tests;
   int                 cycles;

   tdm_fir_filter_8tap #(.COEF_INIT(COEFS)) dut (
      .clk(clk), .srst(srst), .tdm_en(tdm_en), .sample_in(sample_in),
      .sample_ce(sample_ce), .y_out(y_out), .y_valid(y_valid));
   tdm_fir_filter_8tap #(.LOAD_SERIAL(1'b1), .COEF_INIT(COEFS)) dut_serial (
      .clk(clk), .srst(srst), .tdm_en(tdm_en), .sample_in(sample_in),
      .sample_ce(), .y_out(y_out_s), .y_valid(y_valid_s));
   sample_source src (
      .clk(clk), .srst(srst), .sample_ce(sample_ce), .next_val(next_val),
      .sample_in(sample_in));
   // factor four reaches the accumulate path that factor two never uses
   tdm_fir_filter_8tap #(.FACTOR(4), .COEF_INIT(COEFS4)) dut4 (
      .clk(clk), .srst(srst), .tdm_en(tdm_en), .sample_in(sample_in4),
      .sample_ce(sample_ce4), .y_out(y_out4), .y_valid(y_valid4));
   sample_source src4 (
      .clk(clk), .srst(srst), .sample_ce(sample_ce4), .next_val(next_val),
      .sample_in(sample_in4));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input logic signed [39:0] got, input logic signed [39:0] exp,
                        input string what);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t %s got %0d exp %0d", $time, what, got, exp);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // reference sum over the current and seven older samples, queued per period
   always @(posedge clk) begin
      logic signed [38:0] acc;
      logic signed [38:0] e;
      logic signed [17:0] hk;
      if (srst) begin
         hist = '{default: '0};
         expq.delete();
      end else begin
         if (y_valid === 1'b1) begin
            e = (expq.size() > 0) ? expq.pop_front() : '1;
            check(40'(y_out), 40'(e), "parallel result");
            check(40'(y_out_s), 40'(e), "serial result");
         end
         check(40'(y_valid_s), 40'(y_valid), "serial strobe");
         if (sample_ce === 1'b1) begin
            for (int k = 7; k > 0; k--) hist[k] = hist[k-1];
            hist[0] = sample_in;
            acc = '0;
            for (int k = 0; k < 8; k++) begin
               hk = COEFS[18*k +: 18];
               acc = acc + 39'(hist[k]) * 39'(hk);
            end
            expq.push_back(acc);
         end
      end
   end

   // reference for the factor-four build: sixteen taps, one sample every fourth cycle
   always @(posedge clk) begin
      logic signed [39:0] acc4;
      logic signed [39:0] e4;
      logic signed [17:0] hk4;
      if (srst) begin
         hist4 = '{default: '0};
         expq4.delete();
      end else begin
         if (y_valid4 === 1'b1) begin
            e4 = (expq4.size() > 0) ? expq4.pop_front() : '1;
            check(y_out4, e4, "four-cycle result");
         end
         if (sample_ce4 === 1'b1) begin
            for (int k = 15; k > 0; k--) hist4[k] = hist4[k-1];
            hist4[0] = sample_in4;
            acc4 = '0;
            for (int k = 0; k < 16; k++) begin
               hk4 = COEFS4[18*k +: 18];
               acc4 = acc4 + 40'(hist4[k]) * 40'(hk4);
            end
            expq4.push_back(acc4);
         end
      end
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles > 2000) begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic send(input logic signed [17:0] v);
      next_val <= v;
      do @(posedge clk); while (sample_ce !== 1'b1);
   endtask

   task automatic restart(input logic mode);
      tdm_en <= mode;
      srst   <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
   endtask

   task automatic run_stream();
      logic signed [17:0] vals [10];
      vals = '{18'sh00001, 18'sh00000, 18'sh00000, 18'sh1FFFF, 18'sh20000,
               18'sh20000, 18'sh1FFFF, 18'sh00005, 18'sh3FFFD, 18'sh00000};
      foreach (vals[i]) send(vals[i]);
      repeat (9) send(18'sh00000);
      repeat (4) @(posedge clk);
   endtask

   task automatic t_tdm_stream();
      restart(1'b1);
      run_stream();
      $display("test tdm_stream done");
   endtask

   task automatic t_direct_stream();
      restart(1'b0);
      run_stream();
      $display("test direct_stream done");
   endtask

   task automatic t_midrun_reset();
      restart(1'b1);
      send(18'sh1FFFF);
      send(18'sh20000);
      send(18'sh00003);
      restart(1'b1);
      @(posedge clk);
      check(40'(y_out), 40'sh0, "output after reset");
      check(40'(y_valid), 40'sh0, "strobe after reset");
      check(y_out4, 40'sh0, "four-cycle output after reset");
      run_stream();
      $display("test midrun_reset done");
   endtask

   initial begin
      srst        = 1'b1;
      tdm_en      = 1'b1;
      next_val    = 18'sh00000;
      miscompares = 0;
      n_tests     = 0;
      cycles      = 0;
      repeat (2) @(posedge clk);
      t_tdm_stream();
      t_direct_stream();
      t_midrun_reset();
      give_verdict();
   end
endmodule // tdm_fir_filter_8tap_tb
